/* File: rtl/flp_packer.sv */
// Purpose: Packs the cyclical part of the fault log and streams the record to storage.
// Assumes: Sweep results and header bytes come from logic on the same clock.
// Notes:   Sweeps that end while a record is being written are not kept.
`timescale 1ns/1ps
module flp_packer import flp_pkg::*; (
   input  wire logic              clock,                    // 20 MHz core clock
   input  wire logic              reset,                    // Async reset, active high
   input  wire logic              step_done,                // Sequencer step finished, pulse
   input  wire logic [STEP_W-1:0] step_index,               // Number of that step
   input  wire logic              fault,                    // Fault event, pulse
   input  wire logic [15:0]       vout0,                    // Output voltage ch0, mantissa
   input  wire logic [15:0]       vout1,                    // Output voltage ch1, mantissa
   input  wire logic [15:0]       iout0,                    // Output current ch0
   input  wire logic [15:0]       iout1,                    // Output current ch1
   input  wire logic [15:0]       vin,                      // Input voltage
   input  wire logic [15:0]       iin,                      // Input current
   input  wire logic [7:0]        status_vout0,             // Voltage status ch0
   input  wire logic [7:0]        status_vout1,             // Voltage status ch1
   input  wire logic [15:0]       status_word0,             // Status word ch0
   input  wire logic [15:0]       status_word1,             // Status word ch1
   input  wire logic [7:0]        status_mfr0,              // Vendor status ch0
   input  wire logic [7:0]        status_mfr1,              // Vendor status ch1
   output logic [7:0]             hdr_index,                // Header byte wanted
   input  wire logic [7:0]        hdr_byte,                 // Header byte at hdr_index
   output logic                   ee_valid,                 // Record byte offered
   input  wire logic              ee_ready,                 // Storage takes the byte
   output logic [7:0]             ee_index,                 // Record byte number
   output logic [7:0]             ee_data,                  // Record byte value
   output logic                   log_busy,                 // Logging in progress
   output logic [7:0]             fault_record_readout_len  // Block length for readout
);
   flp_state_e state;
   flp_state_e next_state;
   logic [7:0] nidx;
   logic [7:0] next_nidx;
   logic [2:0] nage;
   logic [2:0] next_nage;
   logic [4:0] noff;
   logic [4:0] next_noff;
   logic       next_ee_valid;
   logic [7:0] next_ee_index;
   logic [7:0] next_ee_data;
   logic       log_present;
   logic       next_log_present;
   logic       sweep_end;
   logic       push;
   logic [7:0] store_byte;
   logic [PAGE_BITS-1:0] page_in;

   // A sweep ends when its final sequencer step completes
   assign sweep_end = step_done && (step_index == LAST_STEP);
   // Sweeps during a write are dropped so the logged pages stay put
   assign push      = sweep_end && (state != FLP_WRITE);

   // Page layout, record order, multi-byte fields high byte first
   assign page_in = {vout0, vout1,
                     iout0, iout1, vin, iin,
                     status_vout0, status_vout1,
                     status_word0, status_word1,
                     status_mfr0, status_mfr1};

   flp_page_store #(
      .PAGES (EVENT_PAGES),
      .BITS  (PAGE_BITS)
   ) u_store (
      .clock   (clock),
      .reset   (reset),
      .push    (push),
      .page_in (page_in),
      .rd_age  (nage),
      .rd_byte (noff),
      .rd_data (store_byte),
      .fill    ()
   );

   assign hdr_index = nidx;
   assign log_busy  = (state == FLP_WRITE);
   // Length is a pure function of whether a record exists
   assign fault_record_readout_len = log_present ? REC_LEN : REC_LEN_NONE;

   // Control, byte walker and output register next values
   always_comb begin
      next_state       = state;
      next_nidx        = nidx;
      next_nage        = nage;
      next_noff        = noff;
      next_ee_valid    = ee_valid;
      next_ee_index    = ee_index;
      next_ee_data     = ee_data;
      next_log_present = log_present;
      case (state)
         FLP_IDLE: begin
            if (fault && sweep_end) begin
               next_state = FLP_WRITE;
            end else if (fault) begin
               next_state = FLP_WAIT;
            end
         end
         FLP_WAIT: begin
            // Further faults are absorbed into the pending log
            if (sweep_end) begin
               next_state = FLP_WRITE;
            end
         end
         FLP_WRITE: begin
            if (ee_valid && ee_ready) begin
               next_ee_valid = 1'b0;
            end
            if ((!ee_valid || ee_ready) && (nidx < REC_LEN)) begin
               next_ee_valid = 1'b1;
               next_ee_index = nidx;
               next_ee_data  = (nidx < HDR_LEN) ? hdr_byte : store_byte;
               next_nidx     = nidx + 8'h01;
               if (nidx >= HDR_LEN) begin
                  // Page walk: offset 0..19, then the next older page
                  if (noff == PAGE_LAST) begin
                     next_noff = 5'h00;
                     next_nage = nage + 3'h1;
                  end else begin
                     next_noff = noff + 5'h01;
                  end
               end
            end else if (ee_valid && ee_ready && (nidx == REC_LEN)) begin
               next_state       = FLP_IDLE;
               next_log_present = 1'b1;
            end
         end
         default: begin
            next_state = FLP_IDLE;
         end
      endcase
      // Entering a write restarts the walk at header byte 0
      if (state != FLP_WRITE && next_state == FLP_WRITE) begin
         next_nidx     = 8'h00;
         next_nage     = 3'h0;
         next_noff     = 5'h00;
         next_ee_valid = 1'b0;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state       <= FLP_IDLE;
         nidx        <= 8'h00;
         nage        <= 3'h0;
         noff        <= 5'h00;
         ee_valid    <= 1'b0;
         ee_index    <= 8'h00;
         ee_data     <= 8'h00;
         log_present <= 1'b0;
      end else begin
         state       <= next_state;
         nidx        <= next_nidx;
         nage        <= next_nage;
         noff        <= next_noff;
         ee_valid    <= next_ee_valid;
         ee_index    <= next_ee_index;
         ee_data     <= next_ee_data;
         log_present <= next_log_present;
      end
   end

   // Helper: bytes taken by storage during the current write
   logic [7:0] acc_cnt;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         acc_cnt <= 8'h00;
      end else if (state != FLP_WRITE) begin
         acc_cnt <= 8'h00;
      end else if (ee_valid && ee_ready) begin
         acc_cnt <= acc_cnt + 8'h01;
      end
   end

   wait_sweep_a : assert property (@(posedge clock) disable iff (reset)
      (state == FLP_WAIT && !sweep_end) |=> state == FLP_WAIT)
      else $error("logging began before the sweep ended");
   start_after_sweep_a : assert property (@(posedge clock) disable iff (reset)
      $rose(log_busy) |-> $past(sweep_end) && $past(fault || state == FLP_WAIT))
      else $error("write started without a fault and a sweep end");
   whole_record_a : assert property (@(posedge clock) disable iff (reset)
      (log_busy && next_state == FLP_IDLE) |-> acc_cnt == REC_LEN - 8'h01 && ee_ready)
      else $error("record did not hold 147 bytes");
   newest_base_a : assert property (@(posedge clock) disable iff (reset)
      (log_busy && nidx == NEWEST_BASE + 8'h13) |-> nage == 3'h0 && noff == PAGE_LAST)
      else $error("newest page not at bytes 27 to 46");
   older_base_a : assert property (@(posedge clock) disable iff (reset)
      (log_busy && nidx == OLDER_BASE) |-> nage == 3'h1 && noff == 5'h00)
      else $error("older page not at byte 47");
   len_full_a : assert property (@(posedge clock) disable iff (reset)
      (log_busy ##1 !log_busy) |-> fault_record_readout_len == REC_LEN)
      else $error("length not 147 after a log");
   len_zero_a : assert property (@(posedge clock) disable iff (reset)
      $changed(fault_record_readout_len) |-> $fell(log_busy) && fault_record_readout_len == REC_LEN)
      else $error("length left zero without a finished log");
   mantissa_a : assert property (@(posedge clock) disable iff (reset)
      (log_busy && nidx == NEWEST_BASE + 8'h04) |-> nage == 3'h0 && noff == 5'h04)
      else $error("voltage fields not four mantissa bytes");
endmodule

/* File: rtl/flp_page_store.sv */
// Purpose: Rolling history of the most recent completed sweep pages.
// Assumes: One push per completed sweep; reads are combinational.
// Notes:   Pages not yet filled since reset read as zero bytes.
`timescale 1ns/1ps
module flp_page_store import flp_pkg::*; #(
   parameter int PAGES = EVENT_PAGES,                // Pages of history
   parameter int BITS  = PAGE_BITS                   // Bits per page
) (
   input  wire logic            clock,               // Core clock
   input  wire logic            reset,               // Async reset, active high
   input  wire logic            push,                // Store a completed sweep
   input  wire logic [BITS-1:0] page_in,             // Packed page, byte 0 in top bits
   input  wire logic [2:0]      rd_age,              // 0 is newest
   input  wire logic [4:0]      rd_byte,             // Byte offset inside the page
   output logic [7:0]           rd_data,             // Selected byte
   output logic [3:0]           fill                 // Pages holding data
);
   if (PAGES < 1 || PAGES > 7 || BITS != PAGE_BYTES * 8) begin : g_chk
      $error("flp_page_store: unsupported PAGES or BITS");
   end

   logic [BITS-1:0] pages [PAGES];
   logic [2:0]      wr_ptr;
   logic [2:0]      next_wr_ptr;
   logic [3:0]      next_fill;
   logic [3:0]      slot;

   // Pointer and fill level; the oldest page is overwritten once full
   always_comb begin
      next_wr_ptr = wr_ptr;
      next_fill   = fill;
      if (push) begin
         next_wr_ptr = (wr_ptr == 3'(PAGES - 1)) ? 3'h0 : wr_ptr + 3'h1;
         if (fill != 4'(PAGES)) begin
            next_fill = fill + 4'h1;
         end
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         wr_ptr <= 3'h0;
         fill   <= 4'h0;
      end else begin
         wr_ptr <= next_wr_ptr;
         fill   <= next_fill;
      end
   end

   // Storage needs no reset: the fill level hides stale slots
   always_ff @(posedge clock) begin
      if (push) begin
         pages[wr_ptr] <= page_in;
      end
   end

   // Age to slot: newest sits just behind the write pointer
   always_comb begin
      slot = 4'(wr_ptr) + 4'(PAGES) - 4'h1 - 4'(rd_age);
      if (slot >= 4'(PAGES)) begin
         slot = slot - 4'(PAGES);
      end
      rd_data = 8'h00;
      if (4'(rd_age) < fill && rd_byte <= PAGE_LAST) begin
         rd_data = pages[slot[2:0]][(BITS - 1 - 8 * int'(rd_byte)) -: 8];
      end
   end

   newest_page_a : assert property (@(posedge clock) disable iff (reset)
      push |=> pages[(wr_ptr == 3'h0) ? 3'(PAGES - 1) : wr_ptr - 3'h1] == $past(page_in))
      else $error("newest page differs from the completed sweep");
   history_fill_a : assert property (@(posedge clock) disable iff (reset)
      push |=> fill == (($past(fill) == 4'(PAGES)) ? 4'(PAGES) : $past(fill) + 4'h1))
      else $error("history fill level wrong after a sweep");
endmodule

/* File: rtl/flp_pkg.sv */
// Purpose: Shared constants and types for the fault log event packer.
// Assumes: Record byte layout of the fault log readout, one clock domain.
// Notes:   Indices are record byte numbers, 8 bits wide.
package flp_pkg;
   // Record layout
   localparam logic [7:0] REC_LEN      = 8'h93;   // 147 bytes in a full record
   localparam logic [7:0] REC_LEN_NONE = 8'h00;   // Length when nothing is logged
   localparam logic [7:0] HDR_LEN      = 8'h1b;   // Header bytes 0..26
   localparam logic [7:0] NEWEST_BASE  = 8'h1b;   // Newest event page, byte 27
   localparam logic [7:0] OLDER_BASE   = 8'h2f;   // Next-older event page, byte 47
   localparam logic [4:0] PAGE_LAST    = 5'h13;   // Last byte offset inside a page (19)
   localparam int         PAGE_BYTES   = 20;      // Bytes per event page
   localparam int         PAGE_BITS    = 160;     // Bits per event page
   localparam int         EVENT_PAGES  = 6;       // Pages kept and logged
   // Sweep sequencer
   localparam int         STEP_W       = 5;       // Width of the step number
   localparam logic [4:0] LAST_STEP    = 5'h19;   // Final step of a sweep (25)
   // Packer control states, one-hot
   typedef enum logic [2:0] {
      FLP_IDLE  = 3'b001,
      FLP_WAIT  = 3'b010,
      FLP_WRITE = 3'b100
   } flp_state_e;
endpackage

/* File: tb/flp_storage_model.sv */
// Purpose: Storage and header supplier on the far side of the packer.
// Assumes: A byte is taken at an edge with ee_valid and ee_ready both high.
// Notes:   Slow mode stalls on a fixed pattern to stretch the handshake.
`timescale 1ns/1ps
module flp_storage_model (
   input  wire logic       clock,     // Core clock
   input  wire logic       reset,     // Async reset, active high
   input  wire logic       slow,      // Stall on some cycles
   input  wire logic [7:0] hdr_index, // Header byte wanted
   output logic [7:0]      hdr_byte,  // Header byte supplied
   input  wire logic       ee_valid,  // Byte offered
   output logic            ee_ready,  // Byte taken
   input  wire logic [7:0] ee_index,  // Record byte number
   input  wire logic [7:0] ee_data    // Record byte value
);
   logic [7:0] mem [0:146];           // Bytes stored
   int         taken;                 // Bytes stored since reset
   logic       order_bad;             // Index arrived out of sequence
   logic [2:0] pat;                   // Stall pattern
   // Header is a fixed function of its index so the bench can predict it
   assign hdr_byte = hdr_index ^ 8'ha5;
   // Ready is the pat register bit unless slow is low, so it changes off the edge only when slow does
   assign ee_ready = !slow || pat[0];
   // Take bytes and watch their order
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pat       <= 3'h1;
         taken     <= 0;
         order_bad <= 1'b0;
      end else begin
         pat <= {pat[1:0], pat[2] ^ pat[1]};
         if (ee_valid && ee_ready) begin
            if (ee_index < 8'h93) mem[ee_index] <= ee_data;
            taken <= taken + 1;
            // Each record restarts at index 0; the count runs on across records
            if (int'(ee_index) != taken % 147) order_bad <= 1'b1;
         end
      end
   end
endmodule

/* File: tb/tb_fault_log_event_packer.sv */
// Purpose: Self-checking bench for the fault log event packer.
// Assumes: Storage model on the far side; random data from a fixed seed.
// Notes:   History is predicted in the bench and cleared with every reset.
`timescale 1ns/1ps
module tb_fault_log_event_packer import flp_pkg::*;;
   logic clock = 1'b0, reset = 1'b1, slow = 1'b0;
   logic step_done = 1'b0, fault = 1'b0;
   logic [4:0] step_index = 5'h00;
   logic [15:0] vout0 = 16'h0, vout1 = 16'h0, iout0 = 16'h0, iout1 = 16'h0;
   logic [15:0] vin = 16'h0, iin = 16'h0, status_word0 = 16'h0, status_word1 = 16'h0;
   logic [7:0] status_vout0 = 8'h0, status_vout1 = 8'h0, status_mfr0 = 8'h0, status_mfr1 = 8'h0;
   logic [7:0] hdr_index, hdr_byte, ee_index, ee_data, len;
   logic ee_valid, ee_ready, log_busy;
   logic [159:0] hist [6];
   logic [31:0] seed = 32'h07ff2483;
   int mismatches = 0, n_checks = 0, base = 0;
   int fstep [3] = '{15, 25, 0};
   always #25 clock = ~clock;
   flp_packer uut (.clock(clock), .reset(reset), .step_done(step_done),
      .step_index(step_index), .fault(fault), .vout0(vout0), .vout1(vout1),
      .iout0(iout0), .iout1(iout1), .vin(vin), .iin(iin), .status_vout0(status_vout0),
      .status_vout1(status_vout1), .status_word0(status_word0), .status_word1(status_word1),
      .status_mfr0(status_mfr0), .status_mfr1(status_mfr1), .hdr_index(hdr_index),
      .hdr_byte(hdr_byte), .ee_valid(ee_valid), .ee_ready(ee_ready), .ee_index(ee_index),
      .ee_data(ee_data), .log_busy(log_busy), .fault_record_readout_len(len));
   flp_storage_model model (.clock(clock), .reset(reset), .slow(slow), .hdr_index(hdr_index),
      .hdr_byte(hdr_byte), .ee_valid(ee_valid), .ee_ready(ee_ready), .ee_index(ee_index),
      .ee_data(ee_data));
   // Xorshift source, repeatable from the fixed seed
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Expected record byte: header, then pages newest first, high byte first
   function automatic logic [7:0] expb(int i);
      int k, j;
      if (i < 27) return 8'(i) ^ 8'ha5;
      k = (i - 27) / 20;
      j = (i - 27) % 20;
      return hist[k][159 - 8 * j -: 8];
   endfunction
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Reset held for 20 cycles; the predicted history empties with it
   task automatic do_reset();
      reset = 1'b1;
      foreach (hist[k]) hist[k] = 160'h0;
      repeat (20) @(posedge clock);
      #2 reset = 1'b0;
   endtask
   // One sweep of steps 0..25 with fresh data each step; fault at step fs, none when fs is -1
   task automatic sweep(input int fs);
      for (int s = 0; s <= 25; s++) begin
         @(posedge clock);
         #2 step_done = 1'b1;
         step_index = 5'(s);
         fault = (s == fs);
         {vout0, vout1} = rnd();
         {iout0, iout1} = rnd();
         {vin, iin} = rnd();
         {status_word0, status_word1} = rnd();
         {status_vout0, status_vout1, status_mfr0, status_mfr1} = rnd();
         if (s == 24) check({7'h0, log_busy}, 8'h01 & 8'h00, "busy before sweep end");
      end
      for (int k = 5; k > 0; k--) hist[k] = hist[k - 1];
      hist[0] = {vout0, vout1, iout0, iout1, vin, iin, status_vout0, status_vout1,
                 status_word0, status_word1, status_mfr0, status_mfr1};
      @(posedge clock);
      #2 step_done = 1'b0;
      fault = 1'b0;
   endtask
   // Watchdog well beyond the expected run of about 1000 cycles
   initial begin
      #200000;
      mismatches++;
      stop_test();
   end
   // Three logs: overfilled history, partly filled with stalls, repeat log
   initial begin
      foreach (hist[k]) hist[k] = 160'h0;
      repeat (20) @(posedge clock);
      #2 reset = 1'b0;
      for (int t = 0; t < 3; t++) begin
         if (t == 1) do_reset();
         slow = (t == 1);
         base = model.taken;
         check(len, (t < 2) ? REC_LEN_NONE : REC_LEN, "length before log");
         repeat ((t == 0) ? 7 : 1) sweep(-1);
         sweep(fstep[t]);
         check({7'h0, log_busy}, 8'h01, "log started after sweep");
         // Look off the edge so the values launched there have settled
         for (int n = 0; n < 3000 && (log_busy !== 1'b0 || model.taken - base < 147); n++) begin
            @(posedge clock);
            #2;
         end
         check({7'h0, log_busy}, 8'h00, "write finished");
         check(8'(model.taken - base), 8'h93, "bytes written");
         check({7'h0, model.order_bad}, 8'h00, "byte order");
         check(len, 8'h93, "length after log");
         for (int i = 0; i < 147; i++)
            check(model.mem[i], expb(i), "record byte");
         $display("test %0d done", t);
      end
      stop_test();
   end
endmodule
